//--- logic/dcf_fifo.sv
// dual-clock fifo control: resets, mode, offsets, replay, write and read ports
`timescale 1ns/1ps
module dcf_fifo (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wclk,
	input wire logic rclk,
	input wire logic [dcf_pkg::DATA_W-1:0] din,
	input wire logic wen_n,
	input wire logic ren_n,
	input wire logic load_n,
	input wire logic serial_shift_enable_n,
	input wire logic fallthrough_sel_serial_in,
	input wire logic replay_n,
	input wire logic full_reset_n,
	input wire logic partial_reset_n,
	output logic [dcf_pkg::DATA_W-1:0] q_out,
	output logic empty_n,
	output logic full_n,
	output logic half_n,
	output logic almost_empty_n,
	output logic almost_full_n,
	output logic fall_through_mode,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [dcf_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [dcf_pkg::WB_W-1:0] wb_dat_i,
	output logic [dcf_pkg::WB_W-1:0] wb_dat_o,
	output logic wb_ack_o
);
	import dcf_pkg::*;

	// ****************************************************************
	// pin synchronisers and edge finders
	// ****************************************************************
	logic [CTL_W-1:0] ctl_raw;
	logic [CTL_W-1:0] ctl_s;
	logic [DATA_W-1:0] din_s;
	logic wclk_d_q;
	logic rclk_d_q;
	logic w_ev;
	logic r_ev;
	logic wen_s;
	logic ren_s;
	logic load_s;
	logic sen_s;
	logic si_s;
	logic replay_s;
	logic frst_s;
	logic core_rst_n;

	assign ctl_raw = {full_reset_n, replay_n, fallthrough_sel_serial_in, serial_shift_enable_n,
		load_n, ren_n, wen_n, rclk, wclk};

	dcf_sync #(.W(CTL_W)) u_ctl_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d(ctl_raw),
		.q(ctl_s)
	);

	dcf_sync #(.W(DATA_W)) u_din_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d(din),
		.q(din_s)
	);

	assign wen_s = ctl_s[CTL_WEN];
	assign ren_s = ctl_s[CTL_REN];
	assign load_s = ctl_s[CTL_LOAD];
	assign sen_s = ctl_s[CTL_SEN];
	assign si_s = ctl_s[CTL_SEL_SI];
	assign replay_s = ctl_s[CTL_REPLAY];
	assign frst_s = ctl_s[CTL_FRST];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wclk_d_q <= 1'b0;
			rclk_d_q <= 1'b0;
		end else begin
			wclk_d_q <= ctl_s[CTL_WCLK];
			rclk_d_q <= ctl_s[CTL_RCLK];
		end
	end

	// data and enables pass the same two flops as the clocks, so they line up with the edge
	assign w_ev = ctl_s[CTL_WCLK] & ~wclk_d_q;
	assign r_ev = ctl_s[CTL_RCLK] & ~rclk_d_q;

	// raw reset pins act at once; a glitch on them resets the fifo, that is the price
	assign core_rst_n = arst_n & full_reset_n & partial_reset_n;

	// ****************************************************************
	// mode and loading method, caught while full reset is held
	// ****************************************************************
	dcf_mode_t mode_q;
	logic serial_q;
	logic fall;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= dcf_mode_std;
			serial_q <= 1'b0;
		end else if (!frst_s) begin
			mode_q <= si_s ? dcf_mode_fall : dcf_mode_std;
			serial_q <= load_s;
		end
	end

	// partial reset never reaches these two flops
	assign fall = (mode_q == dcf_mode_fall);
	assign fall_through_mode = fall;

	// ****************************************************************
	// offset registers
	// ****************************************************************
	logic [OFS_W-1:0] ofs_q [2];
	logic ofs_wptr_q;
	logic ofs_rptr_q;
	logic [BITC_W-1:0] bit_cnt_q;
	logic wb_req;
	logic wb_wr;

	function automatic logic [OFS_W-1:0] dcf_lane_merge(input logic [OFS_W-1:0] cur,
		input logic [WB_W-1:0] wd, input logic [3:0] sel);
		logic [15:0] tmp;
		tmp = {3'h0, cur};
		if (sel[0]) begin
			tmp[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			tmp[15:8] = wd[15:8];
		end
		return tmp[OFS_W-1:0];
	endfunction : dcf_lane_merge

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr = wb_req & wb_we_i & ~serial_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ofs_q[0] <= OFS_DEF_PAR;
			ofs_q[1] <= OFS_DEF_PAR;
			ofs_wptr_q <= 1'b0;
			ofs_rptr_q <= 1'b0;
			bit_cnt_q <= BITC_RST;
		end else if (!frst_s) begin
			ofs_q[0] <= load_s ? OFS_DEF_SER : OFS_DEF_PAR;
			ofs_q[1] <= load_s ? OFS_DEF_SER : OFS_DEF_PAR;
			ofs_wptr_q <= 1'b0;
			ofs_rptr_q <= 1'b0;
			bit_cnt_q <= BITC_RST;
		end else begin
			if (w_ev && !load_s) begin
				if (serial_q && !sen_s) begin
					// lsb first, empty offset first, no padding between the two
					ofs_q[ofs_wptr_q][bit_cnt_q] <= si_s;
					if (bit_cnt_q == SER_LAST_BIT) begin
						bit_cnt_q <= BITC_RST;
						ofs_wptr_q <= ~ofs_wptr_q;
					end else begin
						bit_cnt_q <= bit_cnt_q + 1'b1;
					end
				end else if (!serial_q && !wen_s) begin
					ofs_q[ofs_wptr_q] <= din_s[OFS_W-1:0];
					ofs_wptr_q <= ~ofs_wptr_q;
				end
			end
			if (r_ev && !load_s && !ren_s) begin
				ofs_rptr_q <= ~ofs_rptr_q;
			end
			if (wb_wr && wb_adr_i == REG_EMPTY_OFS) begin
				ofs_q[0] <= dcf_lane_merge(ofs_q[0], wb_dat_i, wb_sel_i);
			end
			if (wb_wr && wb_adr_i == REG_FULL_OFS) begin
				ofs_q[1] <= dcf_lane_merge(ofs_q[1], wb_dat_i, wb_sel_i);
			end
		end
	end

	// ****************************************************************
	// write port and storage
	// ****************************************************************
	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [CNT_W-1:0] words_q;
	logic full_act;
	logic wr_do;
	dcf_rp_t rp_q;

	// during setup the array is never reported full; the controller keeps writes off
	assign full_act = (words_q == FULL_COUNT) && (rp_q != dcf_rp_setup);
	assign wr_do = w_ev & ~wen_s & load_s & ~full_act;

	always_ff @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			wr_ptr_q <= PTR_RST;
		end else if (wr_do) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	// no reset on the array: contents are don't-care until written
	always_ff @(posedge clk) begin
		if (wr_do) begin
			mem_q[wr_ptr_q] <= din_s;
		end
	end

	// ****************************************************************
	// read port and replay sequencing
	// ****************************************************************
	logic [PTR_W-1:0] rd_ptr_q;
	logic [PTR_W-1:0] rd_ptr_d;
	logic [CNT_W-1:0] words_d;
	logic [CNT_W-1:0] total_d;
	logic out_valid_q;
	logic out_valid_d;
	logic [2:0] setup_cnt_q;
	logic [2:0] setup_cnt_d;
	dcf_rp_t rp_d;
	logic rd_en;
	logic take;
	logic drain;
	logic q_load;
	logic [PTR_W-1:0] q_src;
	logic ofs_rd;
	logic empty_act;

	always_comb begin
		rd_en = r_ev & ~ren_s & load_s & (rp_q != dcf_rp_setup);
		take = 1'b0;
		drain = 1'b0;
		if (!fall) begin
			take = rd_en & (words_q != WORDS_RST);
		end else begin
			take = r_ev & load_s & (rp_q != dcf_rp_setup) & (words_q != WORDS_RST)
				& (~out_valid_q | ~ren_s);
			drain = rd_en & out_valid_q & (words_q == WORDS_RST);
		end
		words_d = words_q + CNT_W'(wr_do) - CNT_W'(take);
		rd_ptr_d = rd_ptr_q;
		out_valid_d = out_valid_q;
		setup_cnt_d = setup_cnt_q;
		rp_d = rp_q;
		q_load = take;
		q_src = rd_ptr_q;
		if (take) begin
			rd_ptr_d = rd_ptr_q + 1'b1;
			out_valid_d = 1'b1;
		end
		if (drain) begin
			out_valid_d = 1'b0;
		end
		case (rp_q)
			dcf_rp_idle: begin
				rp_d = dcf_rp_idle;
			end
			dcf_rp_setup: begin
				if (r_ev) begin
					if (setup_cnt_q == (fall ? SETUP_LAST_FALL : SETUP_LAST_STD)) begin
						// no wrap since reset, so the write pointer is the word count
						words_d = {1'b0, wr_ptr_q};
						rp_d = dcf_rp_hold;
						if (fall) begin
							rp_d = dcf_rp_idle;
							if (wr_ptr_q != PTR_RST) begin
								words_d = {1'b0, wr_ptr_q} - 1'b1;
								q_load = 1'b1;
								q_src = PTR_RST;
								rd_ptr_d = PTR_RST + 1'b1;
								out_valid_d = 1'b1;
							end
						end
					end else begin
						setup_cnt_d = setup_cnt_q + 1'b1;
					end
				end
			end
			dcf_rp_hold: begin
				if (take) begin
					rp_d = dcf_rp_idle;
				end
			end
			default: begin
				rp_d = dcf_rp_idle;
			end
		endcase
		if (r_ev && !replay_s && rp_q != dcf_rp_setup) begin
			rp_d = dcf_rp_setup;
			setup_cnt_d = SETUP_CNT_RST;
			rd_ptr_d = PTR_RST;
			out_valid_d = 1'b0;
			words_d = words_q + CNT_W'(wr_do);
			q_load = 1'b0;
		end
		total_d = words_d + CNT_W'(out_valid_d);
	end

	always_ff @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			rd_ptr_q <= PTR_RST;
			words_q <= WORDS_RST;
			out_valid_q <= 1'b0;
			setup_cnt_q <= SETUP_CNT_RST;
			rp_q <= dcf_rp_idle;
		end else begin
			rd_ptr_q <= rd_ptr_d;
			words_q <= words_d;
			out_valid_q <= out_valid_d;
			setup_cnt_q <= setup_cnt_d;
			rp_q <= rp_d;
		end
	end

	assign ofs_rd = r_ev & ~load_s & ~ren_s;

	always_ff @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			q_out <= Q_RST;
		end else if (q_load) begin
			q_out <= mem_q[q_src];
		end else if (ofs_rd) begin
			q_out <= {{(DATA_W-OFS_W){1'b0}}, ofs_q[ofs_rptr_q]};
		end
	end

	// ****************************************************************
	// flags
	// ****************************************************************
	logic freeze;
	logic upd;
	logic half_q;
	logic [2:0] ae_p_q;
	logic [2:0] af_p_q;
	logic ae_now;
	logic af_now;

	// empty side: standard reports the array, fall-through the output word
	assign empty_act = fall ? ~out_valid_q : ((words_q == WORDS_RST) || (rp_q == dcf_rp_setup));
	assign empty_n = fall ? empty_act : ~empty_act;
	assign full_n = fall ? full_act : ~full_act;

	// half and the first almost-flag stages hold still through setup and, in standard mode, until the first read
	assign freeze = (rp_d != dcf_rp_idle);
	assign upd = (r_ev | w_ev) & ~freeze;
	assign ae_now = total_d > {1'b0, ofs_q[0]};
	assign af_now = ({1'b0, total_d} + {2'b00, ofs_q[1]}) < {1'b0, FULL_COUNT};

	always_ff @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			half_q <= 1'b1;
		end else if (upd) begin
			half_q <= ~(total_d > HALF_COUNT);
		end
	end

	// almost-empty lags two read edges behind half
	always_ff @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			ae_p_q <= AE_PIPE_RST;
		end else begin
			if (upd) begin
				ae_p_q[0] <= ae_now;
			end
			if (r_ev) begin
				ae_p_q[2:1] <= ae_p_q[1:0];
			end
		end
	end

	// almost-full lags two write edges; a write edge in the same cycle counts as skew too small
	always_ff @(posedge clk or negedge core_rst_n) begin
		if (!core_rst_n) begin
			af_p_q <= AF_PIPE_RST;
		end else begin
			if (upd) begin
				af_p_q[0] <= af_now;
			end
			if (w_ev) begin
				af_p_q[2:1] <= af_p_q[1:0];
			end
		end
	end

	assign half_n = half_q;
	assign almost_empty_n = ae_p_q[2];
	assign almost_full_n = af_p_q[2];

	// ****************************************************************
	// wishbone slave
	// ****************************************************************
	logic [STAT_W-1:0] status_w;
	logic [WB_W-1:0] wb_dat_q;
	logic ack_q;

	always_comb begin
		status_w = '0;
		status_w[ST_MODE] = fall;
		status_w[ST_SERIAL] = serial_q;
		status_w[ST_EMPTY] = empty_act;
		status_w[ST_FULL] = full_act;
		status_w[ST_HALF_N] = half_q;
		status_w[ST_AE_N] = ae_p_q[2];
		status_w[ST_AF_N] = af_p_q[2];
		status_w[ST_SETUP] = (rp_q == dcf_rp_setup);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
			wb_dat_q <= WB_DAT_RST;
		end else begin
			ack_q <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					REG_STATUS: wb_dat_q <= {{(WB_W-STAT_W){1'b0}}, status_w};
					REG_LEVEL: wb_dat_q <= {{(WB_W-CNT_W){1'b0}}, words_q + CNT_W'(out_valid_q)};
					REG_EMPTY_OFS: wb_dat_q <= {{(WB_W-OFS_W){1'b0}}, ofs_q[0]};
					REG_FULL_OFS: wb_dat_q <= {{(WB_W-OFS_W){1'b0}}, ofs_q[1]};
					default: wb_dat_q <= WB_DAT_RST;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = wb_dat_q;
endmodule : dcf_fifo

//--- logic/dcf_pkg.sv
// package: constants, types and register map of the dual-clock fifo control
// ****************************************************************
// ****************************************************************
package dcf_pkg;
	localparam int DATA_W = 18;
	localparam int DEPTH = 8192;
	localparam int PTR_W = 13;
	localparam int CNT_W = 14;
	localparam int OFS_W = 13;
	localparam int BITC_W = 4;
	localparam int WB_W = 32;
	localparam int ADDR_W = 8;
	localparam int STAT_W = 8;
	localparam logic [BITC_W-1:0] SER_LAST_BIT = 4'hC;
	localparam logic [BITC_W-1:0] BITC_RST = 4'h0;
	localparam logic [OFS_W-1:0] OFS_DEF_PAR = 13'h007F;
	localparam logic [OFS_W-1:0] OFS_DEF_SER = 13'h03FF;
	localparam logic [CNT_W-1:0] FULL_COUNT = 14'h2000;
	localparam logic [CNT_W-1:0] HALF_COUNT = 14'h1000;
	localparam logic [CNT_W-1:0] WORDS_RST = 14'h0000;
	localparam logic [PTR_W-1:0] PTR_RST = 13'h0000;
	localparam logic [DATA_W-1:0] Q_RST = 18'h00000;
	localparam logic [2:0] AE_PIPE_RST = 3'h0;
	localparam logic [2:0] AF_PIPE_RST = 3'h7;
	// read-clock periods that replay setup may take in each mode
	localparam int REPLAY_RCLK_PERIODS_STD = 3;
	localparam int REPLAY_RCLK_PERIODS_FALL = 4;
	localparam logic [2:0] SETUP_LAST_STD = 3'(REPLAY_RCLK_PERIODS_STD - 1);
	localparam logic [2:0] SETUP_LAST_FALL = 3'(REPLAY_RCLK_PERIODS_FALL - 1);
	localparam logic [2:0] SETUP_CNT_RST = 3'h0;
	// synchronised pin vector
	localparam int CTL_W = 9;
	localparam int CTL_WCLK = 0;
	localparam int CTL_RCLK = 1;
	localparam int CTL_WEN = 2;
	localparam int CTL_REN = 3;
	localparam int CTL_LOAD = 4;
	localparam int CTL_SEN = 5;
	localparam int CTL_SEL_SI = 6;
	localparam int CTL_REPLAY = 7;
	localparam int CTL_FRST = 8;
	// register map
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] REG_LEVEL = 8'h04;
	localparam logic [ADDR_W-1:0] REG_EMPTY_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_FULL_OFS = 8'h0C;
	localparam logic [WB_W-1:0] WB_DAT_RST = 32'h00000000;
	// status fields
	localparam int ST_MODE = 0;
	localparam int ST_SERIAL = 1;
	localparam int ST_EMPTY = 2;
	localparam int ST_FULL = 3;
	localparam int ST_HALF_N = 4;
	localparam int ST_AE_N = 5;
	localparam int ST_AF_N = 6;
	localparam int ST_SETUP = 7;
	typedef enum logic {dcf_mode_std, dcf_mode_fall} dcf_mode_t;
	typedef enum logic [1:0] {dcf_rp_idle, dcf_rp_setup, dcf_rp_hold} dcf_rp_t;
endpackage : dcf_pkg

//--- logic/dcf_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module dcf_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// meta_q feeds q only, nothing else may look at it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : dcf_sync

//--- testbench/dcf_fifo_props.sv
// checker: properties on the fifo control top ports
`timescale 1ns/1ps
module dcf_fifo_props (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [dcf_pkg::DATA_W-1:0] q_out,
	input wire logic empty_n,
	input wire logic full_n,
	input wire logic half_n,
	input wire logic almost_empty_n,
	input wire logic almost_full_n,
	input wire logic fall_through_mode,
	input wire logic replay_n,
	input wire logic full_reset_n,
	input wire logic partial_reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	import dcf_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// ****************
	// resets, mode, replay and bus acknowledge
	// ****************
	a_full_rst_out: assert property (
		!full_reset_n |-> half_n && !almost_empty_n && almost_full_n && q_out == Q_RST)
		else $error("full reset left flags or output wrong");
	a_part_rst_out: assert property (
		!partial_reset_n |-> half_n && !almost_empty_n && almost_full_n && q_out == Q_RST)
		else $error("partial reset left flags or output wrong");
	a_std_rst_flags: assert property (
		(!full_reset_n || !partial_reset_n) && !fall_through_mode |-> !empty_n && full_n)
		else $error("standard reset flags wrong");
	a_fall_rst_flags: assert property (
		(!full_reset_n || !partial_reset_n) && fall_through_mode |-> empty_n && !full_n)
		else $error("fall-through reset flags wrong");
	a_mode_kept: assert property (
		full_reset_n && $past(full_reset_n, 4) && !partial_reset_n |=> $stable(fall_through_mode))
		else $error("partial reset changed the mode");
	a_mode_only_full: assert property (
		$changed(fall_through_mode) |-> !$past(full_reset_n, 2) || !$past(full_reset_n, 3)
			|| !$past(full_reset_n, 4))
		else $error("mode changed outside full reset");
	// pin sync lag plus half a read period before the capturing edge
	a_std_replay_end: assert property (
		!fall_through_mode && $fell(replay_n) |-> ##[1:20] !empty_n ##[1:300] empty_n)
		else $error("standard replay setup did not end in time");
	a_fall_replay_end: assert property (
		fall_through_mode && $fell(replay_n) |-> ##[1:20] empty_n ##[1:320] !empty_n)
		else $error("fall-through replay setup did not end in time");
	a_wb_ack_next: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus cycle not acknowledged after one clock");
	a_wb_ack_pulse: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge held longer than one clock");
endmodule : dcf_fifo_props
bind dcf_fifo dcf_fifo_props chk_u (.clk, .arst_n, .q_out, .empty_n, .full_n, .half_n,
	.almost_empty_n, .almost_full_n, .fall_through_mode, .replay_n, .full_reset_n,
	.partial_reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

//--- testbench/dcf_pins_model.sv
// partner model: system logic on the pin side, makes both pin clocks
`timescale 1ns/1ps
module dcf_pins_model (
	input wire logic clk,
	input wire logic arst_n,
	output logic wclk,
	output logic rclk,
	output logic [dcf_pkg::DATA_W-1:0] din,
	output logic wen_n,
	output logic ren_n,
	output logic serial_shift_enable_n,
	output logic fallthrough_sel_serial_in,
	output logic replay_n
);
	import dcf_pkg::*;
	logic [3:0] wcnt_q;
	logic [3:0] rcnt_q;
	// ****************
	// free-running pin clocks, 160 ns, read side shifted in phase
	// ****************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wcnt_q <= 4'h0;
			rcnt_q <= 4'h5;
		end else begin
			wcnt_q <= wcnt_q + 4'h1;
			rcnt_q <= rcnt_q + 4'h1;
		end
	end
	assign wclk = wcnt_q < 4'h8;
	assign rclk = rcnt_q < 4'h8;
	initial begin
		din = '0;
		wen_n = 1'b1;
		ren_n = 1'b1;
		serial_shift_enable_n = 1'b1;
		fallthrough_sel_serial_in = 1'b0;
		replay_n = 1'b1;
	end
	// one request held from a falling pin edge over the next rising one
	task automatic pin_cycle(input bit on_r, input int d, input logic w, input logic r,
		input logic s, input logic i, input logic rp);
		do @(posedge clk); while ((on_r ? rcnt_q : wcnt_q) != 4'h8);
		din <= d[DATA_W-1:0];
		wen_n <= w;
		ren_n <= r;
		serial_shift_enable_n <= s;
		fallthrough_sel_serial_in <= i;
		replay_n <= rp;
		do @(posedge clk); while ((on_r ? rcnt_q : wcnt_q) != 4'h8);
		// idle data is scrambled so a late capture cannot pass by luck
		din <= ~d[DATA_W-1:0];
		wen_n <= 1'b1;
		ren_n <= 1'b1;
		serial_shift_enable_n <= 1'b1;
		replay_n <= 1'b1;
	endtask : pin_cycle
endmodule : dcf_pins_model

//--- testbench/dcf_fifo_test.sv
// testbench: fifo control against a queue model in both modes
`timescale 1ns/1ps
module dcf_fifo_test;
	import dcf_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic load_n = 1'b1;
	logic full_reset_n = 1'b0;
	logic partial_reset_n = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [ADDR_W-1:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h3;
	logic [WB_W-1:0] wb_dat_i = 32'h00000000;
	logic wclk, rclk, wen_n, ren_n, serial_shift_enable_n, fallthrough_sel_serial_in, replay_n;
	logic [DATA_W-1:0] din;
	logic [DATA_W-1:0] q_out;
	logic empty_n, full_n, half_n, almost_empty_n, almost_full_n, fall_through_mode, wb_ack_o;
	logic [WB_W-1:0] wb_dat_o;
	logic [31:0] rd;
	int mismatches = 0;
	int samples_checked = 0;
	int mq[$];
	dcf_fifo dut_u (.clk, .arst_n, .wclk, .rclk, .din, .wen_n, .ren_n, .load_n,
		.serial_shift_enable_n, .fallthrough_sel_serial_in, .replay_n, .full_reset_n,
		.partial_reset_n, .q_out, .empty_n, .full_n, .half_n, .almost_empty_n, .almost_full_n,
		.fall_through_mode, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o);
	dcf_pins_model pm_u (.clk, .arst_n, .wclk, .rclk, .din, .wen_n, .ren_n,
		.serial_shift_enable_n, .fallthrough_sel_serial_in, .replay_n);
	initial begin
		forever #5 clk = ~clk;
	end
	// ****************
	// shared tasks
	// ****************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		wb_sel_i <= 4'h3;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
		check(n < 20, 1);
	endtask : wb
	task automatic wait_empty(input logic v);
		int n;
		n = 0;
		while (empty_n !== v && n < 600) begin
			@(posedge clk);
			n++;
		end
		check(empty_n, v);
	endtask : wait_empty
	// fall-through shows the head word unrequested; standard needs a read per word
	task automatic drain(input logic ft);
		for (int k = 0; k < mq.size(); k++) begin
			if (!ft || k > 0) pm_u.pin_cycle(1'b1, 0, 1'b1, 1'b0, 1'b1, ft, 1'b1);
			check(q_out, mq[k]);
		end
	endtask : drain
	task automatic full_rst(input logic ft, input logic ld);
		load_n <= ld;
		pm_u.pin_cycle(1'b0, 0, 1'b1, 1'b1, 1'b1, ft, 1'b1);
		full_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		check({fall_through_mode, empty_n, full_n, half_n, almost_empty_n, almost_full_n},
			{ft, ft, !ft, 3'b101});
		check(q_out, 0);
		full_reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		load_n <= 1'b1;
		mq.delete();
	endtask : full_rst
	// ****************
	// one pass per mode: offsets, writes, reads, replay, partial reset; serial load in the fall-through pass only
	// ****************
	task automatic run_mode(input logic ft);
		int w;
		logic [31:0] sv;
		logic [31:0] eo;
		logic [31:0] fo;
		full_rst(ft, ft);
		wb(1'b0, REG_FULL_OFS, 0);
		check(rd, ft ? OFS_DEF_SER : OFS_DEF_PAR);
		wb(1'b1, REG_EMPTY_OFS, 32'h55);
		wb(1'b0, REG_EMPTY_OFS, 0);
		check(rd, ft ? OFS_DEF_SER : 32'h55);
		wb(1'b0, 8'h40, 0);
		check(rd, 0);
		check(q_out, 0);
		for (int k = 0; k < 3; k++) begin
			w = $urandom & 32'h3FFFF;
			mq.push_back(w);
			pm_u.pin_cycle(1'b0, w, 1'b0, 1'b1, 1'b1, ft, 1'b1);
		end
		pm_u.pin_cycle(1'b0, 32'h1234, 1'b1, 1'b1, 1'b1, ft, 1'b1);
		wb(1'b0, REG_LEVEL, 0);
		check(rd, 32'h3);
		check(full_n, !ft);
		pm_u.pin_cycle(1'b1, 0, 1'b1, 1'b1, 1'b1, ft, 1'b1);
		drain(ft);
		pm_u.pin_cycle(1'b1, 0, 1'b1, 1'b1, 1'b1, ft, 1'b0);
		wait_empty(!ft);
		// three words: under half, at or below the empty offset, far from full
		check({half_n, almost_empty_n, almost_full_n}, 3'b101);
		drain(ft);
		sv = $urandom & 32'h3FFFFFF;
		load_n <= 1'b0;
		for (int k = 0; k < 26; k++) pm_u.pin_cycle(1'b0, 0, 1'b1, 1'b1, 1'b0, sv[k], 1'b1);
		load_n <= 1'b1;
		eo = ft ? (sv & 32'h1FFF) : 32'h55;
		fo = ft ? (sv >> 13) : OFS_DEF_PAR;
		partial_reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		check({fall_through_mode, empty_n, full_n, q_out}, {ft, ft, !ft, Q_RST});
		partial_reset_n <= 1'b1;
		wb(1'b0, REG_EMPTY_OFS, 0);
		check(rd, eo);
		wb(1'b0, REG_FULL_OFS, 0);
		check(rd, fo);
		$display("mode %0d pass done", ft);
	endtask : run_mode
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	initial begin
		#200000;
		mismatches++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h6AD9));
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		run_mode(1'b0);
		run_mode(1'b1);
		complete_run();
	end
endmodule : dcf_fifo_test
